// ---- src/ph_pkg.sv ----
// How it works
// - command register low byte holds the command byte sent to the keyboard
// - setting send_enable starts transmitting the stored command byte
// - send_enable clears itself when the transmission has finished
// - with trap set, shift codes 0x12/0x59 never reach the scan register
// - with trap set, shift codes only move shift-held and clear pending extend/release prefixes; no receive interrupt
// - trap bit is clear after reset
// - hold clock low over 60 us, then data low and clock released in the same cycle, bits on falls
// - receive 11-bit frames: start, 8 data lsb first, odd parity, stop
// - transmit-complete flag sets at end of write; software writes one to clear
// - transmit-error flag set on missing ack, cleared at next write start
`default_nettype none
package ph_pkg;
  localparam logic [31:0] CMD_ADDR   = 32'hfff8_9000;
  localparam logic [31:0] STS_ADDR   = 32'hfff8_9004;
  localparam logic [31:0] SCAN_ADDR  = 32'hfff8_9008;
  localparam logic [31:0] ASCII_ADDR = 32'hfff8_900c;
  localparam int CMD_SEND  = 8;
  localparam int CMD_TRAP  = 9;
  localparam int STS_RXIRQ = 0;
  localparam int STS_TXIRQ = 4;
  localparam int STS_TXERR = 5;
  localparam int SCAN_EXT  = 8;
  localparam int SCAN_REL  = 9;
  localparam int SCAN_SHF  = 10;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [7:0] CODE_SHL = 8'h12;
  localparam logic [7:0] CODE_SHR = 8'h59;
  localparam logic [7:0] CODE_EXT = 8'he0;
  localparam logic [7:0] CODE_REL = 8'hf0;
  localparam int HOLD_US  = 60;
  localparam int MCLK_MHZ = 100;
  // strictly more than the hold time
  localparam int HOLD_CYC = HOLD_US * MCLK_MHZ + 1;
  localparam logic [3:0] RX_STOP = 4'ha;
  localparam logic [3:0] TX_ACK  = 4'ha;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [2:0] {TX_IDLE, TX_INHIBIT, TX_START, TX_BITS, TX_DONE}
    ph_tx_t;
  function automatic logic ph_is_shift(input logic [7:0] c);
    return (c == CODE_SHL) || (c == CODE_SHR);
  endfunction
endpackage
`default_nettype wire

// ---- src/ph_fifo.sv ----
`default_nettype none
// depth must be a power of two
module ph_fifo
  import ph_pkg::*;
#(
  parameter int W = 8,
  parameter int D = FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_r;
  logic [AW:0]  wr_nxt;
  logic [AW:0]  rd_r;
  logic [AW:0]  rd_nxt;
  logic         push;
  logic         pop;

  assign in_ready  = !((wr_r[AW] != rd_r[AW]) &&
                       (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign out_valid = (wr_r != rd_r);
  assign out_data  = mem[rd_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  // storage carries no reset; empty flag guards reads
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- src/ph_ctrl.sv ----
`default_nettype none
module ph_ctrl
  import ph_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PS2_CLK,
  output logic             PS2_CLK_DRV,
  output logic             PS2_CLK_OE,
  input  wire logic        PS2_DAT,
  output logic             PS2_DAT_DRV,
  output logic             PS2_DAT_OE
);
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pslverr_r, pslverr_nxt, drv_r;
  logic [7:0]  cmd_r, cmd_nxt;
  logic        send_r, send_nxt, trap_r, trap_nxt;
  logic        txirq_r, txirq_nxt, txerr_r, txerr_nxt;
  logic        rxirq_r, rxirq_nxt;
  logic [7:0]  scan_r, scan_nxt;
  logic        sext_r, sext_nxt, srel_r, srel_nxt;
  logic        ext_r, ext_nxt, rel_r, rel_nxt, shf_r, shf_nxt;
  ph_tx_t      st_r, st_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic [9:0]  txsh_r, txsh_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic        clkoe_r, clkoe_nxt, datoe_r, datoe_nxt;
  logic        ack_r, ack_nxt, busy_r;
  logic        ck_s1, ck_s2, ck_s3, dt_s1, dt_s2;
  logic        tg_s1, tg_s2, tg_s3;
  logic        pend_r, pend_nxt;
  logic [7:0]  pbyte_r, pbyte_nxt;
  logic        fin_rdy, fout_vld, pop;
  logic [7:0]  fout;
  logic        setup, wr_cmd, wr_sts, fall, tx_done, tx_start;
  // link domain
  logic [3:0]  rcnt_r, rcnt_nxt;
  logic [7:0]  rsh_r, rsh_nxt, rbyte_r, rbyte_nxt;
  logic        rpar_r, rpar_nxt, rtog_r, rtog_nxt;

  assign PRDATA      = prdata_r;
  assign PREADY      = pready_r;
  assign PSLVERR     = pslverr_r;
  assign PS2_CLK_OE  = clkoe_r;
  assign PS2_DAT_OE  = datoe_r;
  assign PS2_CLK_DRV = drv_r;
  assign PS2_DAT_DRV = drv_r;

  assign setup    = PSEL && !PENABLE;
  assign wr_cmd   = PSEL && PENABLE && PWRITE && (PADDR == CMD_ADDR);
  assign wr_sts   = PSEL && PENABLE && PWRITE && (PADDR == STS_ADDR);
  assign fall     = ck_s3 && !ck_s2;
  assign tx_done  = (st_r == TX_DONE);
  assign tx_start = (st_r == TX_IDLE) && send_r;
  assign pop      = fout_vld && !rxirq_r;

  ////////////////////////////////////////////////////////////////////////
  // apb: read data latched in setup so it stands through the access phase
  always_comb begin
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      pslverr_nxt = 1'b0;
      case (PADDR)
        CMD_ADDR:   prdata_nxt = {22'h0, trap_r, send_r, cmd_r};
        STS_ADDR:   prdata_nxt = {26'h0, txerr_r, txirq_r, 3'h0, rxirq_r};
        SCAN_ADDR:  prdata_nxt = {21'h0, shf_r, srel_r, sext_r, scan_r};
        ASCII_ADDR: prdata_nxt = REG_RESET;
        default: begin
          prdata_nxt  = REG_RESET;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and status registers
  always_comb begin
    cmd_nxt   = cmd_r;
    send_nxt  = send_r;
    trap_nxt  = trap_r;
    txirq_nxt = txirq_r;
    txerr_nxt = txerr_r;
    if (wr_cmd) begin
      cmd_nxt  = PWDATA[7:0];
      trap_nxt = PWDATA[CMD_TRAP];
      // a busy transfer cannot be restarted or cancelled
      if (PWDATA[CMD_SEND] && st_r == TX_IDLE) send_nxt = 1'b1;
    end
    if (tx_done) send_nxt = 1'b0;
    if (wr_sts && PWDATA[STS_TXIRQ]) txirq_nxt = 1'b0;
    if (tx_done) txirq_nxt = 1'b1;
    if (tx_start) txerr_nxt = 1'b0;
    if (tx_done) txerr_nxt = !ack_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit sequencer on mclk, link clock seen through synchronisers
  always_comb begin
    st_nxt    = st_r;
    hold_nxt  = hold_r;
    txsh_nxt  = txsh_r;
    bit_nxt   = bit_r;
    clkoe_nxt = clkoe_r;
    datoe_nxt = datoe_r;
    ack_nxt   = ack_r;
    case (st_r)
      TX_IDLE: begin
        if (send_r) begin
          st_nxt    = TX_INHIBIT;
          hold_nxt  = 16'h0000;
          clkoe_nxt = 1'b1;
          ack_nxt   = 1'b0;
          txsh_nxt  = {1'b1, ~^cmd_r, cmd_r};
        end
      end
      TX_INHIBIT: begin
        hold_nxt = hold_r + 16'h0001;
        if (hold_r == 16'(HOLD_CYCLES - 1)) begin
          clkoe_nxt = 1'b0;
          datoe_nxt = 1'b1;
          st_nxt    = TX_START;
        end
      end
      TX_START: begin
        if (fall) begin
          datoe_nxt = !txsh_r[0];
          txsh_nxt  = {1'b1, txsh_r[9:1]};
          bit_nxt   = 4'h1;
          st_nxt    = TX_BITS;
        end
      end
      TX_BITS: begin
        if (fall) begin
          if (bit_r == TX_ACK) begin
            ack_nxt   = !dt_s2;
            datoe_nxt = 1'b0;
            st_nxt    = TX_DONE;
          end else begin
            datoe_nxt = !txsh_r[0];
            txsh_nxt  = {1'b1, txsh_r[9:1]};
            bit_nxt   = bit_r + 4'h1;
          end
        end
      end
      TX_DONE: st_nxt = TX_IDLE;
      default: st_nxt = TX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // receive path: link byte crosses by toggle, queued, then reported
  always_comb begin
    pend_nxt  = pend_r;
    pbyte_nxt = pbyte_r;
    if (pend_r && fin_rdy) pend_nxt = 1'b0;
    // a full queue loses the held pending byte, not the newer link frame
    // own transmit bits look like a frame; the toggle lands by the done cycle
    if (tg_s2 != tg_s3 && !busy_r) begin
      pend_nxt  = 1'b1;
      pbyte_nxt = rbyte_r;
    end
  end

  always_comb begin
    scan_nxt  = scan_r;
    sext_nxt  = sext_r;
    srel_nxt  = srel_r;
    ext_nxt   = ext_r;
    rel_nxt   = rel_r;
    shf_nxt   = shf_r;
    rxirq_nxt = rxirq_r;
    if (wr_sts && PWDATA[STS_RXIRQ]) rxirq_nxt = 1'b0;
    if (pop) begin
      if (fout == CODE_EXT) begin
        ext_nxt = 1'b1;
      end else if (fout == CODE_REL) begin
        rel_nxt = 1'b1;
      end else begin
        if (ph_is_shift(fout)) shf_nxt = !rel_r;
        if (!(trap_r && ph_is_shift(fout))) begin
          scan_nxt  = fout;
          sext_nxt  = ext_r;
          srel_nxt  = rel_r;
          rxirq_nxt = 1'b1;
        end
        ext_nxt = 1'b0;
        rel_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_r  <= REG_RESET;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      drv_r     <= 1'b0;
      cmd_r     <= REG_RESET[7:0];
      send_r    <= 1'b0;
      trap_r    <= 1'b0;
      txirq_r   <= 1'b0;
      txerr_r   <= 1'b0;
      rxirq_r   <= 1'b0;
      scan_r    <= 8'h00;
      sext_r    <= 1'b0;
      srel_r    <= 1'b0;
      ext_r     <= 1'b0;
      rel_r     <= 1'b0;
      shf_r     <= 1'b0;
      st_r      <= TX_IDLE;
      hold_r    <= 16'h0000;
      txsh_r    <= 10'h000;
      bit_r     <= 4'h0;
      clkoe_r   <= 1'b0;
      datoe_r   <= 1'b0;
      ack_r     <= 1'b0;
      busy_r    <= 1'b0;
      {ck_s1, ck_s2, ck_s3} <= 3'h7;
      {dt_s1, dt_s2}        <= 2'h3;
      {tg_s1, tg_s2, tg_s3} <= 3'h0;
      pend_r    <= 1'b0;
      pbyte_r   <= 8'h00;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= 1'b1;
      pslverr_r <= pslverr_nxt;
      drv_r     <= 1'b0;
      cmd_r     <= cmd_nxt;
      send_r    <= send_nxt;
      trap_r    <= trap_nxt;
      txirq_r   <= txirq_nxt;
      txerr_r   <= txerr_nxt;
      rxirq_r   <= rxirq_nxt;
      scan_r    <= scan_nxt;
      sext_r    <= sext_nxt;
      srel_r    <= srel_nxt;
      ext_r     <= ext_nxt;
      rel_r     <= rel_nxt;
      shf_r     <= shf_nxt;
      st_r      <= st_nxt;
      hold_r    <= hold_nxt;
      txsh_r    <= txsh_nxt;
      bit_r     <= bit_nxt;
      clkoe_r   <= clkoe_nxt;
      datoe_r   <= datoe_nxt;
      ack_r     <= ack_nxt;
      busy_r    <= (st_nxt != TX_IDLE);
      {ck_s1, ck_s2, ck_s3} <= {PS2_CLK, ck_s1, ck_s2};
      {dt_s1, dt_s2}        <= {PS2_DAT, dt_s1};
      {tg_s1, tg_s2, tg_s3} <= {rtog_r, tg_s1, tg_s2};
      pend_r    <= pend_nxt;
      pbyte_r   <= pbyte_nxt;
    end
  end

  ph_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .in_valid  (pend_r),
    .in_ready  (fin_rdy),
    .in_data   (pbyte_r),
    .out_valid (fout_vld),
    .out_ready (!rxirq_r),
    .out_data  (fout)
  );

  ////////////////////////////////////////////////////////////////////////
  // link domain: frames sampled on falling edges of the keyboard clock
  always_comb begin
    rcnt_nxt  = rcnt_r;
    rsh_nxt   = rsh_r;
    rpar_nxt  = rpar_r;
    rbyte_nxt = rbyte_r;
    rtog_nxt  = rtog_r;
    // host bits are counted like a frame so the count is back at zero after
    if (rcnt_r == 4'h0) begin
      if (!PS2_DAT) rcnt_nxt = 4'h1;
      rpar_nxt = 1'b0;
    end else if (rcnt_r == RX_STOP) begin
      if (PS2_DAT && rpar_r) begin
        rbyte_nxt = rsh_r;
        rtog_nxt  = !rtog_r;
      end
      rcnt_nxt = 4'h0;
    end else begin
      if (rcnt_r != 4'h9) rsh_nxt = {PS2_DAT, rsh_r[7:1]};
      rpar_nxt = rpar_r ^ PS2_DAT;
      rcnt_nxt = rcnt_r + 4'h1;
    end
  end

  always_ff @(negedge PS2_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rcnt_r  <= 4'h0;
      rsh_r   <= 8'h00;
      rpar_r  <= 1'b0;
      rbyte_r <= 8'h00;
      rtog_r  <= 1'b0;
    end else begin
      rcnt_r  <= rcnt_nxt;
      rsh_r   <= rsh_nxt;
      rpar_r  <= rpar_nxt;
      rbyte_r <= rbyte_nxt;
      rtog_r  <= rtog_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  cmd_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $changed(cmd_r) |-> $past(wr_cmd) && cmd_r == $past(PWDATA[7:0]))
    else $error("command byte changed without a write");
  send_start_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    tx_start |=> st_r == TX_INHIBIT && clkoe_r)
    else $error("send enable did not start a transfer");
  send_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    tx_done |=> !send_r && st_r == TX_IDLE)
    else $error("send enable not cleared at end");
  trap_scan_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    pop && trap_r && ph_is_shift(fout) |=> $stable(scan_r) && !rxirq_r)
    else $error("trapped shift code reached scan register");
  shift_flag_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    pop && ph_is_shift(fout) && !rel_r |=> shf_r)
    else $error("shift held flag not set");
  trap_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(trap_r) |-> $past(wr_cmd) && $past(PWDATA[CMD_TRAP]))
    else $error("trap bit set without a write");
  inhibit_len_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $fell(clkoe_r) |-> datoe_r && $past(hold_r) == 16'(HOLD_CYCLES - 1))
    else $error("clock released before hold time");
  rx_frame_a: assert property (@(negedge PS2_CLK) disable iff (!RST_N)
    $changed(rtog_r) |-> $past(rcnt_r) == RX_STOP && $past(rpar_r))
    else $error("byte taken outside a valid frame");
  tx_irq_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    tx_done |=> txirq_r && txerr_r == !$past(ack_r))
    else $error("transmit complete flag missing");
  tx_err_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    tx_start |=> !txerr_r)
    else $error("transmit error not cleared at start");
  tx_end_c: cover property (@(posedge MCLK) disable iff (!RST_N) tx_done);
  rx_irq_c: cover property (@(posedge MCLK) disable iff (!RST_N)
    $rose(rxirq_r));
  trap_c: cover property (@(posedge MCLK) disable iff (!RST_N)
    pop && trap_r && ph_is_shift(fout));
  full_c: cover property (@(posedge MCLK) disable iff (!RST_N) !fin_rdy);
endmodule
`default_nettype wire

// ---- verification/ph_kbd.sv ----
`default_nettype none
module ph_kbd (
  input  wire logic clk_oe,
  input  wire logic ps2_dat,
  output var logic  clk_low,
  output var logic  dat_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // lines are only pulled low here; released lines float up to idle high
  initial begin
    clk_low = 1'b0;
    dat_low = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // device to host frame, clock runs only within the frame
  task automatic send_frame(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      dat_low = ~f[i];
      #3.5 clk_low = 1'b1;
      #7.5 clk_low = 1'b0;
      #4;
    end
    dat_low = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // slow clocking: the host reacts in system clocks, so wide phases
  task automatic take_cmd(input logic ack, output logic [9:0] got);
    wait (clk_oe);
    wait (!clk_oe && !ps2_dat);
    // keep link edges clear of the system clock's sampling edge
    #103;
    for (int k = 1; k < 12; k++) begin
      if (k > 1) got[k-2] = ps2_dat;
      if (k == 11) dat_low = ack;
      clk_low = 1'b1;
      #40 clk_low = 1'b0;
      #300;
    end
    dat_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/test_ps2_host_command_control.sv ----
`default_nettype none
module test_ps2_host_command_control
  import ph_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HOLD = 40;
  logic        mclk = 1'b0;
  logic        rst_n;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clk_drv, clk_oe, dat_drv, dat_oe;
  logic        kb_clk_low, kb_dat_low;
  wire logic   ps2_clk = !(clk_oe | kb_clk_low);
  wire logic   ps2_dat = !(dat_oe | kb_dat_low);
  int          error_cnt = 0;
  int          compares = 0;
  logic [31:0] v;
  logic        e;

  always #5 mclk = ~mclk;

  ph_ctrl #(.HOLD_CYCLES(HOLD)) dut (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PS2_CLK(ps2_clk),
    .PS2_CLK_DRV(clk_drv), .PS2_CLK_OE(clk_oe), .PS2_DAT(ps2_dat),
    .PS2_DAT_DRV(dat_drv), .PS2_DAT_OE(dat_oe)
  );

  ph_kbd kb (
    .clk_oe(clk_oe), .ps2_dat(ps2_dat),
    .clk_low(kb_clk_low), .dat_low(kb_dat_low)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // zero wait state bus; answer taken at the access edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (!pready) @(posedge mclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v, e);
  endtask

  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0, v, e);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic send_cmd(input logic [7:0] b, input logic ack);
    logic [9:0] got;
    int n;
    wr(CMD_ADDR, {23'h0, 1'b1, b});
    fork
      kb.take_cmd(ack, got);
      begin
        n = 0;
        @(negedge mclk);
        while (!clk_oe && n < 10) begin
          @(negedge mclk);
          n++;
        end
        n = 0;
        while (clk_oe && n < 10000) begin
          @(negedge mclk);
          n++;
        end
        chk("hold cycles", n, HOLD);
        chk("start bit drive", {31'h0, dat_oe}, 32'h1);
        rd(CMD_ADDR);
        chk("send busy", v[9:0], {2'b01, b});
        rd(STS_ADDR);
        chk("err cleared at start", v[5], 32'h0);
      end
    join
    chk("sent byte", got[7:0], b);
    chk("sent parity", got[8], ~^b);
    chk("sent stop", got[9], 32'h1);
    n = 0;
    v = '0;
    while (!v[STS_TXIRQ] && n < 50) begin
      rd(STS_ADDR);
      n++;
    end
    chk("tx status", v[5:4], {!ack, 1'b1});
    rd(CMD_ADDR);
    chk("send self clear", v[8], 32'h0);
    wr(STS_ADDR, 32'h10);
    rd(STS_ADDR);
    chk("tx irq clear", v[4], 32'h0);
  endtask

  task automatic rx(input logic [7:0] b, input logic bad, input logic irq,
                    input logic [10:0] scan);
    kb.send_frame(b, bad);
    repeat (12) @(negedge mclk);
    rd(STS_ADDR);
    chk("rx irq", v[0], irq);
    rd(SCAN_ADDR);
    chk("scan word", v, {21'h0, scan});
    wr(STS_ADDR, 32'h1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic reset_values;
    rd(CMD_ADDR);
    chk("cmd reset", v, REG_RESET);
    chk("bus status", {30'h0, pready, e}, 32'h2);
    chk("open drain", {30'h0, clk_drv, dat_drv}, 32'h0);
    rd(ASCII_ADDR);
    chk("ascii reads zero", v, REG_RESET);
    rd(STS_ADDR);
    chk("sts reset", v, REG_RESET);
    rd(SCAN_ADDR);
    chk("scan reset", v, REG_RESET);
    rd(32'hfff8_9010);
    chk("unmapped err", {31'h0, e}, 32'h1);
    wr(CMD_ADDR, 32'h0000_02a5);
    rd(CMD_ADDR);
    chk("cmd readback", v, 32'h0000_02a5);
    wr(CMD_ADDR, 32'h0);
  endtask

  task automatic shift_filter;
    rx(8'h1c, 1'b0, 1'b1, 11'h01c);
    rx(8'h1c, 1'b1, 1'b0, 11'h01c);
    rx(8'h12, 1'b0, 1'b1, 11'h412);
    rx(CODE_REL, 1'b0, 1'b0, 11'h412);
    rx(8'h12, 1'b0, 1'b1, 11'h212);
    wr(CMD_ADDR, 32'h0000_0200);
    rx(8'h59, 1'b0, 1'b0, 11'h612);
    rx(CODE_EXT, 1'b0, 1'b0, 11'h612);
    rx(8'h1c, 1'b0, 1'b1, 11'h51c);
  endtask

  // back to back frames queue up while the first one is pending
  task automatic queued_frames;
    for (int i = 0; i < 3; i++) kb.send_frame(8'h15 + i[7:0], 1'b0);
    repeat (12) @(negedge mclk);
    for (int i = 0; i < 3; i++) begin
      rd(SCAN_ADDR);
      chk("queued code", v[7:0], 8'h15 + i[7:0]);
      wr(STS_ADDR, 32'h1);
      repeat (4) @(negedge mclk);
    end
  endtask

  initial begin
    // fall from unknown so both clock domains see the reset edge
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    reset_values();
    send_cmd(8'hed, 1'b1);
    send_cmd(8'hf4, 1'b0);
    send_cmd(8'h01, 1'b1);
    shift_filter();
    queued_frames();
    tally_and_finish();
  end

  initial begin
    #200us;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
